// ---- inc/iqcmc_regs.vh ----
// Purpose: constants of the four-channel mode control block
// Assumes: AHB-Lite register window, byte addresses, 32-bit words
// Notes: byte offsets, field positions, reset values, codes
// Function
// (R1) four independent channels, own mode and switches
// (R2) mode code maps onto switch pair, HH invalid
// (R3) source switch picks RF or LO
// (R4) route switch picks calibration or experiment
// (R5) every channel powers up in RF mode
// (R6) LED blue RF, green LO, orange calibration
// (R7) newer units host control, older use pins
// (R8) enable pin hands switches to digital input
// (R9) host sends UDP mode requests to port
// (R10) dynamic address else fall back to default
// (R11) dynamic failure reported, default address announced
// (R12) console commands never change channel modes
// (R13) console line rate fixed for both ends
// (R14) startup banner: address, hardware address, help hint
// (R15) help lists every configuration command
// (R16) disable command turns dynamic off, acknowledges
// (R17) set address command prompts dotted quad
// (R18) await confirm word or back re-prompt
// (R19) confirm restarts with new address
// (R20) request carries channel 1..4 and mode
`ifndef IQCMC_REGS_VH
`define IQCMC_REGS_VH

`define IQCMC_A_CTRL 8'h00
`define IQCMC_A_STATUS 8'h04
`define IQCMC_A_CONS_CMD 8'h08
`define IQCMC_A_ADDR_ENTRY 8'h0C
`define IQCMC_A_ACTIVE_ADDR 8'h10
`define IQCMC_A_NET_EVT 8'h14
`define IQCMC_A_LEASE 8'h18
`define IQCMC_A_UDP_REQ 8'h1C
`define IQCMC_A_MSG 8'h20
`define IQCMC_A_HWADDR_LO 8'h24
`define IQCMC_A_HWADDR_HI 8'h28
`define IQCMC_A_BAUD_DIV 8'h2C

`define IQCMC_CTRL_DYN 0
`define IQCMC_CTRL_CUSTOM 1
`define IQCMC_CTRL_GROUP 2
`define IQCMC_CTRL_BCAST 3
`define IQCMC_CTRL_RST 4'h1

`define IQCMC_DEFAULT_ADDR 32'hC0A8B21B
`define IQCMC_UDP_PORT 16'h1092

`define IQCMC_MODE_RF 2'h0
`define IQCMC_MODE_LO 2'h1
`define IQCMC_MODE_CAL 2'h2
`define IQCMC_MODE_BAD 2'h3

`define IQCMC_CMD_HELP 4'h1
`define IQCMC_CMD_DYN_OFF 4'h2
`define IQCMC_CMD_DYN_ON 4'h3
`define IQCMC_CMD_SET_ADDR 4'h4
`define IQCMC_CMD_DEFAULT 4'h5
`define IQCMC_CMD_CUSTOM 4'h6
`define IQCMC_CMD_GROUP_ON 4'h7
`define IQCMC_CMD_GROUP_OFF 4'h8
`define IQCMC_CMD_BCAST_ON 4'h9
`define IQCMC_CMD_BCAST_OFF 4'hA
`define IQCMC_CMD_CONFIRM 4'hB
`define IQCMC_CMD_BACK 4'hC

`define IQCMC_MSG_NONE 4'h0
`define IQCMC_MSG_BANNER 4'h1
`define IQCMC_MSG_DYN_FAIL 4'h2
`define IQCMC_MSG_HELP 4'h3
`define IQCMC_MSG_DONE 4'h4
`define IQCMC_MSG_ADDR_PROMPT 4'h5
`define IQCMC_MSG_CONFIRM_PROMPT 4'h6

`define IQCMC_CLK_HZ 125000000
`define IQCMC_BAUD 115200

`endif

// ---- rtl/iqcmc_chan.v ----
// Purpose: one channel, mode code to switch drives and status LED
// Assumes: requested code from the same clock domain
// Notes: invalid code keeps the mode already applied
`timescale 1ns/100ps
`default_nettype none
`include "iqcmc_regs.vh"

module iqcmc_chan
(
	input wire i_clk,
	input wire i_rstn,
	input wire [1:0] i_mode,
	output reg o_src_sw,
	output reg o_route_sw,
	output reg o_led_blue,
	output reg o_led_green,
	output reg o_led_orange,
	output wire [1:0] o_mode
);

	reg [1:0] mode_r;
	reg [1:0] mode_nxt;

	assign o_mode = mode_r;

	always @*
	begin
		mode_nxt = mode_r;
		if (i_mode != `IQCMC_MODE_BAD) // see (R2)
			mode_nxt = i_mode;
	end

	always @(posedge i_clk)
	begin
		if (!i_rstn)
		begin
			mode_r <= `IQCMC_MODE_RF; // see (R5)
			o_src_sw <= 1'b0;
			o_route_sw <= 1'b0;
			o_led_blue <= 1'b1;
			o_led_green <= 1'b0;
			o_led_orange <= 1'b0;
		end
		else
		begin
			mode_r <= mode_nxt;
			o_src_sw <= (mode_nxt == `IQCMC_MODE_LO); // see (R3)
			o_route_sw <= (mode_nxt == `IQCMC_MODE_CAL); // see (R4)
			o_led_blue <= (mode_nxt == `IQCMC_MODE_RF); // see (R6)
			o_led_green <= (mode_nxt == `IQCMC_MODE_LO);
			o_led_orange <= (mode_nxt == `IQCMC_MODE_CAL);
		end
	end

endmodule

`default_nettype wire

// ---- rtl/iqcmc_top.v ----
// Purpose: mode control of four IQ channels with console address set-up
// Assumes: firmware carries UDP payloads and console text to registers
// Notes: AHB-Lite slave, zero wait states, always OKAY
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/100ps
`default_nettype none
`include "iqcmc_regs.vh"

module iqcmc_top
#(
	parameter NCH = 4,
	parameter [31:0] HWADDR_LO = 32'h00A1B2C3, // arbitrary value
	parameter [15:0] HWADDR_HI = 16'h0200 // arbitrary value
)
(
	input wire I_REF_CLK,
	input wire I_RSTN,
	input wire I_HSEL,
	input wire [31:0] I_HADDR,
	input wire [1:0] I_HTRANS,
	input wire I_HWRITE,
	input wire [2:0] I_HSIZE,
	input wire [31:0] I_HWDATA,
	input wire I_HREADY,
	output reg [31:0] O_HRDATA,
	output reg O_HREADYOUT,
	output reg O_HRESP,
	input wire I_LEGACY_UNIT,
	input wire I_DIN_EN,
	input wire [3:0] I_DIN_SRC,
	input wire [3:0] I_DIN_ROUTE,
	output wire [3:0] O_EXP_SOURCE_SWITCH,
	output wire [3:0] O_RF_ROUTE_SWITCH,
	output wire [3:0] O_LED_BLUE,
	output wire [3:0] O_LED_GREEN,
	output wire [3:0] O_LED_ORANGE,
	output reg O_RESTART
);

	localparam [1:0] ST_BOOT = 2'b00;
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_WAIT_ADDR = 2'b10;
	localparam [1:0] ST_WAIT_CONFIRM = 2'b11;
	localparam [15:0] BAUD_DIV = 16'h043D; // 125 MHz / 115200, nearest

	// two-flop synchronisers for all pins
	reg [9:0] pin_s1_r;
	reg [9:0] pin_s2_r;
	wire legacy_s = pin_s2_r[9];
	wire din_en_s = pin_s2_r[8];

	// bus capture
	reg wr_pend_r;
	reg [7:0] wr_addr_r;

	// control state
	reg [3:0] ctrl_r;
	reg [1:0] st_r;
	reg [31:0] entry_r;
	reg [31:0] custom_r;
	reg [31:0] active_r;
	reg [31:0] lease_r;
	reg [3:0] msg_r;
	reg [7:0] msg_cnt_r;
	reg [2*NCH-1:0] host_mode_r;

	wire [2*NCH-1:0] applied;
	reg [2*NCH-1:0] req_mode;
	reg [31:0] rd_data;
	wire wr_en = wr_pend_r;
	wire [3:0] cmd = I_HWDATA[3:0];

	function is_wr;
		input [7:0] a;
		input [7:0] off;
		begin
			is_wr = wr_en && (a == off);
		end
	endfunction

	function [31:0] fallback_addr;
		input use_custom;
		input [31:0] custom;
		begin
			fallback_addr = use_custom ? custom : `IQCMC_DEFAULT_ADDR;
		end
	endfunction

	always @(posedge I_REF_CLK)
	begin
		if (!I_RSTN)
		begin
			pin_s1_r <= 10'h000;
			pin_s2_r <= 10'h000;
		end
		else
		begin
			pin_s1_r <= {I_LEGACY_UNIT, I_DIN_EN, I_DIN_ROUTE, I_DIN_SRC};
			pin_s2_r <= pin_s1_r;
		end
	end

	// mode source: pins on older units or when the enable pin is up
	integer k;
	integer m;
	always @*
	begin
		req_mode = host_mode_r;
		for (k = 0; k < NCH; k = k + 1)
		begin
			if (legacy_s || din_en_s) // see (R7) see (R8)
				req_mode[2*k +: 2] = {pin_s2_r[4+k], pin_s2_r[k]};
		end
	end

	genvar g;
	generate
		for (g = 0; g < NCH; g = g + 1)
		begin : chan
			iqcmc_chan u_chan
			(
				.i_clk(I_REF_CLK),
				.i_rstn(I_RSTN),
				.i_mode(req_mode[2*g +: 2]), // see (R1)
				.o_src_sw(O_EXP_SOURCE_SWITCH[g]),
				.o_route_sw(O_RF_ROUTE_SWITCH[g]),
				.o_led_blue(O_LED_BLUE[g]),
				.o_led_green(O_LED_GREEN[g]),
				.o_led_orange(O_LED_ORANGE[g]),
				.o_mode(applied[2*g +: 2])
			);
		end
	endgenerate

	// read mux, sampled in the address phase
	always @*
	begin
		rd_data = 32'h00000000;
		case (I_HADDR[7:0])
			`IQCMC_A_CTRL: rd_data = {28'h0000000, ctrl_r};
			`IQCMC_A_STATUS: rd_data = {26'h0000000, din_en_s, legacy_s, 2'b00, st_r};
			`IQCMC_A_ADDR_ENTRY: rd_data = entry_r;
			`IQCMC_A_ACTIVE_ADDR: rd_data = active_r;
			`IQCMC_A_LEASE: rd_data = lease_r;
			`IQCMC_A_UDP_REQ: rd_data = {`IQCMC_UDP_PORT, applied, host_mode_r}; // see (R20)
			`IQCMC_A_MSG: rd_data = {16'h0000, msg_cnt_r, 4'h0, msg_r};
			`IQCMC_A_HWADDR_LO: rd_data = HWADDR_LO;
			`IQCMC_A_HWADDR_HI: rd_data = {16'h0000, HWADDR_HI};
			`IQCMC_A_BAUD_DIV: rd_data = {16'h0000, BAUD_DIV}; // see (R13)
			default: rd_data = 32'h00000000;
		endcase
	end

	// AHB-Lite slave, no wait states
	always @(posedge I_REF_CLK)
	begin
		if (!I_RSTN)
		begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			O_HRDATA <= 32'h00000000;
			O_HREADYOUT <= 1'b1;
			O_HRESP <= 1'b0;
		end
		else
		begin
			O_HREADYOUT <= 1'b1;
			O_HRESP <= 1'b0;
			wr_pend_r <= 1'b0;
			if (I_HSEL && I_HTRANS[1] && I_HREADY)
			begin
				wr_pend_r <= I_HWRITE;
				wr_addr_r <= {I_HADDR[7:2], 2'b00};
				if (!I_HWRITE)
					O_HRDATA <= rd_data;
			end
		end
	end

	// host mode requests: channel 1..4 in bits 2:0, mode in bits 5:4
	always @(posedge I_REF_CLK)
	begin
		if (!I_RSTN)
			host_mode_r <= {NCH{`IQCMC_MODE_RF}}; // see (R5)
		else if (is_wr(wr_addr_r, `IQCMC_A_UDP_REQ)) // see (R9) see (R20)
		begin
			for (m = 0; m < NCH; m = m + 1)
			begin
				if ((I_HWDATA[2:0] == m + 1) && (I_HWDATA[5:4] != `IQCMC_MODE_BAD))
					host_mode_r[2*m +: 2] <= I_HWDATA[5:4];
			end
		end
	end

	// console and network configuration; touches no channel mode
	always @(posedge I_REF_CLK) // see (R12)
	begin
		if (!I_RSTN)
		begin
			ctrl_r <= `IQCMC_CTRL_RST;
			st_r <= ST_BOOT;
			entry_r <= 32'h00000000;
			custom_r <= `IQCMC_DEFAULT_ADDR;
			active_r <= `IQCMC_DEFAULT_ADDR;
			lease_r <= 32'h00000000;
			msg_r <= `IQCMC_MSG_NONE;
			msg_cnt_r <= 8'h00;
			O_RESTART <= 1'b0;
		end
		else
		begin
			O_RESTART <= 1'b0;
			if (is_wr(wr_addr_r, `IQCMC_A_LEASE))
				lease_r <= I_HWDATA;
			if (is_wr(wr_addr_r, `IQCMC_A_CTRL))
				ctrl_r <= I_HWDATA[3:0];
			case (st_r)
				ST_BOOT:
				begin
					if (!ctrl_r[`IQCMC_CTRL_DYN])
					begin
						active_r <= fallback_addr(ctrl_r[`IQCMC_CTRL_CUSTOM], custom_r);
						msg_r <= `IQCMC_MSG_BANNER; // see (R14)
						msg_cnt_r <= msg_cnt_r + 8'h01;
						st_r <= ST_IDLE;
					end
					else if (is_wr(wr_addr_r, `IQCMC_A_NET_EVT) && I_HWDATA[0])
					begin
						active_r <= lease_r; // see (R10)
						msg_r <= `IQCMC_MSG_BANNER; // see (R14)
						msg_cnt_r <= msg_cnt_r + 8'h01;
						st_r <= ST_IDLE;
					end
					else if (is_wr(wr_addr_r, `IQCMC_A_NET_EVT) && I_HWDATA[1])
					begin
						active_r <= `IQCMC_DEFAULT_ADDR; // see (R10)
						msg_r <= `IQCMC_MSG_DYN_FAIL; // see (R11)
						msg_cnt_r <= msg_cnt_r + 8'h01;
						st_r <= ST_IDLE;
					end
				end
				ST_IDLE:
				begin
					if (is_wr(wr_addr_r, `IQCMC_A_CONS_CMD))
					begin
						msg_cnt_r <= msg_cnt_r + 8'h01;
						msg_r <= `IQCMC_MSG_DONE;
						case (cmd)
							`IQCMC_CMD_HELP: msg_r <= `IQCMC_MSG_HELP; // see (R15)
							`IQCMC_CMD_DYN_OFF: ctrl_r[`IQCMC_CTRL_DYN] <= 1'b0; // see (R16)
							`IQCMC_CMD_DYN_ON: ctrl_r[`IQCMC_CTRL_DYN] <= 1'b1;
							`IQCMC_CMD_DEFAULT: ctrl_r[`IQCMC_CTRL_CUSTOM] <= 1'b0;
							`IQCMC_CMD_CUSTOM: ctrl_r[`IQCMC_CTRL_CUSTOM] <= 1'b1;
							`IQCMC_CMD_GROUP_ON: ctrl_r[`IQCMC_CTRL_GROUP] <= 1'b1;
							`IQCMC_CMD_GROUP_OFF: ctrl_r[`IQCMC_CTRL_GROUP] <= 1'b0;
							`IQCMC_CMD_BCAST_ON: ctrl_r[`IQCMC_CTRL_BCAST] <= 1'b1;
							`IQCMC_CMD_BCAST_OFF: ctrl_r[`IQCMC_CTRL_BCAST] <= 1'b0;
							`IQCMC_CMD_SET_ADDR:
							begin
								msg_r <= `IQCMC_MSG_ADDR_PROMPT; // see (R17)
								st_r <= ST_WAIT_ADDR;
							end
							default: msg_r <= `IQCMC_MSG_HELP;
						endcase
					end
				end
				ST_WAIT_ADDR:
				begin
					// firmware turns the four decimal octets into one word
					if (is_wr(wr_addr_r, `IQCMC_A_ADDR_ENTRY)) // see (R17)
					begin
						entry_r <= I_HWDATA;
						msg_r <= `IQCMC_MSG_CONFIRM_PROMPT; // see (R18)
						msg_cnt_r <= msg_cnt_r + 8'h01;
						st_r <= ST_WAIT_CONFIRM;
					end
				end
				ST_WAIT_CONFIRM:
				begin
					if (is_wr(wr_addr_r, `IQCMC_A_CONS_CMD) && cmd == `IQCMC_CMD_CONFIRM)
					begin
						custom_r <= entry_r; // see (R19)
						ctrl_r[`IQCMC_CTRL_CUSTOM] <= 1'b1;
						O_RESTART <= 1'b1;
						st_r <= ST_BOOT;
					end
					else if (is_wr(wr_addr_r, `IQCMC_A_CONS_CMD) && cmd == `IQCMC_CMD_BACK)
					begin
						msg_r <= `IQCMC_MSG_ADDR_PROMPT; // see (R18)
						msg_cnt_r <= msg_cnt_r + 8'h01;
						st_r <= ST_WAIT_ADDR;
					end
				end
				default: st_r <= ST_IDLE;
			endcase
		end
	end

endmodule

`default_nettype wire

// ---- verif/iqcmc_chk_monitor.sv ----
// Purpose: port checker of the channel mode block
// Assumes: single clock, synchronous active-low reset
// Notes: pin relations allow for the input synchronisers
`timescale 1ns/100ps
`default_nettype none

module iqcmc_chk_monitor
(
	input wire I_REF_CLK,
	input wire I_RSTN,
	input wire I_LEGACY_UNIT,
	input wire I_DIN_EN,
	input wire [3:0] I_DIN_SRC,
	input wire [3:0] I_DIN_ROUTE,
	input wire O_HREADYOUT,
	input wire O_HRESP,
	input wire [3:0] O_EXP_SOURCE_SWITCH,
	input wire [3:0] O_RF_ROUTE_SWITCH,
	input wire [3:0] O_LED_BLUE,
	input wire [3:0] O_LED_GREEN,
	input wire [3:0] O_LED_ORANGE,
	input wire O_RESTART
);
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RSTN);
	AST_READY: assert property (O_HREADYOUT) else $error("slave stalled");
	AST_OKAY: assert property (!O_HRESP) else $error("error response");
	AST_NO_HH: assert property ((O_EXP_SOURCE_SWITCH & O_RF_ROUTE_SWITCH) == 4'h0)
		else $error("both switches high");
	AST_BLUE: assert property (O_LED_BLUE == ~(O_EXP_SOURCE_SWITCH | O_RF_ROUTE_SWITCH))
		else $error("blue led wrong");
	AST_GREEN: assert property (O_LED_GREEN == (O_EXP_SOURCE_SWITCH & ~O_RF_ROUTE_SWITCH))
		else $error("green led wrong");
	AST_ORANGE: assert property (O_LED_ORANGE == O_RF_ROUTE_SWITCH)
		else $error("orange led wrong");
	AST_PWRUP: assert property ($rose(I_RSTN) |-> !O_EXP_SOURCE_SWITCH && !O_RF_ROUTE_SWITCH)
		else $error("not in rf mode after reset");
	AST_PULSE: assert property (O_RESTART |=> !O_RESTART) else $error("restart too long");
	AST_PINS: assert property (((I_LEGACY_UNIT || I_DIN_EN) && $stable(I_DIN_SRC)
		&& $stable(I_DIN_ROUTE) && (I_DIN_SRC & I_DIN_ROUTE) == 4'h0)[*6]
		|-> O_EXP_SOURCE_SWITCH == I_DIN_SRC && O_RF_ROUTE_SWITCH == I_DIN_ROUTE)
		else $error("switches do not follow pins");
endmodule

bind iqcmc_top iqcmc_chk_monitor iqcmc_chk_monitor_i (.I_REF_CLK(I_REF_CLK), .I_RSTN(I_RSTN),
	.I_LEGACY_UNIT(I_LEGACY_UNIT), .I_DIN_EN(I_DIN_EN), .I_DIN_SRC(I_DIN_SRC),
	.I_DIN_ROUTE(I_DIN_ROUTE), .O_HREADYOUT(O_HREADYOUT), .O_HRESP(O_HRESP),
	.O_EXP_SOURCE_SWITCH(O_EXP_SOURCE_SWITCH), .O_RF_ROUTE_SWITCH(O_RF_ROUTE_SWITCH),
	.O_LED_BLUE(O_LED_BLUE), .O_LED_GREEN(O_LED_GREEN), .O_LED_ORANGE(O_LED_ORANGE),
	.O_RESTART(O_RESTART));
`default_nettype wire

// ---- verif/iqcmc_dio_model.sv ----
// Purpose: external digital output card driving the switch pins
// Assumes: two-bit mode per channel, channel 1 in the low bits
// Notes: never drives the invalid high-high pair
`timescale 1ns/100ps
`default_nettype none

module iqcmc_dio_model
(
	input wire logic [7:0] i_modes,
	output logic [3:0] o_src,
	output logic [3:0] o_route
);
	always_comb
	begin
		for (int i = 0; i < 4; i++)
		begin
			o_src[i] = (i_modes[2*i+:2] == 2'h1);
			o_route[i] = (i_modes[2*i+:2] == 2'h2);
		end
	end
endmodule
`default_nettype wire

// ---- verif/test_iq_channel_mode_control.sv ----
// Purpose: self-checking bench of the channel mode block
// Assumes: zero-wait AHB-Lite slave, single word transfers
// Notes: entry write assumed to raise the confirm prompt
`timescale 1ns/100ps
`default_nettype none
`include "iqcmc_regs.vh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_total++; \
	$display("ERROR %0t got %h exp %h", $time, g, e); end end

module test_iq_channel_mode_control;
	logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, legacy = 0, din_en = 0;
	logic [1:0] htrans = 0;
	logic [31:0] haddr = 0, hwdata = 0, q, hrdata;
	logic [7:0] pin_modes = 0;
	wire hready;
	wire [3:0] dsrc, droute, src, route, blue, green, orange;
	wire hresp, restart;
	int err_total = 0, n_compared = 0, cyc = 0, n_restart = 0;
	logic [15:0] rows [7] = '{16'h1110, 16'h2212, 16'h1352, 16'h245A, 16'h335A, 16'h014A,
		16'h1268};
	iqcmc_dio_model iqcmc_dio_model_i (.i_modes(pin_modes), .o_src(dsrc), .o_route(droute));
	iqcmc_top #(.HWADDR_LO(32'h00ABCDEF)) iqcmc_top_i (.I_REF_CLK(clk), .I_RSTN(rstn),
		.I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2),
		.I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata), .O_HREADYOUT(hready),
		.O_HRESP(hresp), .I_LEGACY_UNIT(legacy), .I_DIN_EN(din_en), .I_DIN_SRC(dsrc),
		.I_DIN_ROUTE(droute), .O_EXP_SOURCE_SWITCH(src), .O_RF_ROUTE_SWITCH(route),
		.O_LED_BLUE(blue), .O_LED_GREEN(green), .O_LED_ORANGE(orange), .O_RESTART(restart));
	always #4 clk = ~clk;
	always @(posedge clk)
	begin
		cyc++;
		if (restart === 1'b1)
			n_restart++;
		if (cyc == 20000)
		begin
			err_total++;
			results();
		end
	end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge clk);
		while (hready !== 1'b1) @(posedge clk);
		q = hrdata;
	endtask
	task automatic settle(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial
	begin
		repeat (16) @(posedge clk);
		rstn <= 1;
		@(posedge clk);
		`CHK({src, route, blue}, 12'h00F)
		bus(0, `IQCMC_A_ACTIVE_ADDR, 0);
		`CHK(q, 32'hC0A8B21B)
		bus(0, `IQCMC_A_CTRL, 0);
		`CHK(q[0], 1'b1)
		bus(0, `IQCMC_A_HWADDR_LO, 0);
		`CHK(q, 32'h00ABCDEF)
		bus(0, 8'h40, 0);
		`CHK(q, 32'h0)
		bus(1, `IQCMC_A_NET_EVT, 32'h2);
		bus(0, `IQCMC_A_MSG, 0);
		`CHK(q[3:0], `IQCMC_MSG_DYN_FAIL)
		for (int i = 0; i < 7; i++)
		begin
			bus(1, `IQCMC_A_UDP_REQ, {24'h0, rows[i][15:8]});
			settle(3);
			`CHK({src, route}, rows[i][7:0])
			`CHK(green, src & ~route)
		end
		bus(0, `IQCMC_A_UDP_REQ, 0);
		`CHK(q[31:8], 24'h109294)
		pin_modes <= 8'h49;
		din_en <= 1;
		settle(8);
		`CHK({src, route}, 8'h92)
		din_en <= 0;
		legacy <= 1;
		pin_modes <= 8'h24;
		settle(8);
		`CHK({src, route}, 8'h24)
		legacy <= 0;
		settle(8);
		`CHK({src, route}, 8'h68)
		bus(1, `IQCMC_A_CONS_CMD, `IQCMC_CMD_HELP);
		bus(0, `IQCMC_A_MSG, 0);
		`CHK(q[3:0], `IQCMC_MSG_HELP)
		bus(1, `IQCMC_A_CONS_CMD, `IQCMC_CMD_DYN_OFF);
		bus(0, `IQCMC_A_MSG, 0);
		`CHK(q[3:0], `IQCMC_MSG_DONE)
		bus(0, `IQCMC_A_CTRL, 0);
		`CHK(q[0], 1'b0)
		bus(1, `IQCMC_A_CONS_CMD, `IQCMC_CMD_SET_ADDR);
		bus(0, `IQCMC_A_STATUS, 0);
		`CHK(q[1:0], 2'h2)
		bus(1, `IQCMC_A_ADDR_ENTRY, 32'hC0A8B2FE);
		bus(0, `IQCMC_A_MSG, 0);
		`CHK(q[3:0], `IQCMC_MSG_CONFIRM_PROMPT)
		bus(1, `IQCMC_A_CONS_CMD, `IQCMC_CMD_BACK);
		bus(0, `IQCMC_A_MSG, 0);
		`CHK(q[3:0], `IQCMC_MSG_ADDR_PROMPT)
		bus(1, `IQCMC_A_ADDR_ENTRY, 32'hC0A8B264);
		bus(1, `IQCMC_A_CONS_CMD, `IQCMC_CMD_CONFIRM);
		settle(4);
		`CHK(n_restart, 1)
		bus(0, `IQCMC_A_ACTIVE_ADDR, 0);
		`CHK(q, 32'hC0A8B264)
		bus(0, `IQCMC_A_MSG, 0);
		`CHK(q[3:0], `IQCMC_MSG_BANNER)
		`CHK({src, route}, 8'h68)
		rstn <= 0;
		settle(4);
		rstn <= 1;
		settle(2);
		`CHK({src, route, orange}, 12'h000)
		results();
	end
endmodule
`default_nettype wire
